// ### frt_pkg.sv
`default_nettype none
package frt_pkg;
    // Clock and timer step, in ns
    localparam int CLK_PERIOD_NS = 4;
    localparam int TIMER_STEP_NS = 1000;
    localparam int DIV_CYCLES = TIMER_STEP_NS / CLK_PERIOD_NS;
    // Timer geometry
    localparam int TIMER_W = 12;
    localparam int TICK_A_US = 128;
    localparam int TICK_B_US = 1024;
    localparam int TICK_A_BITS = $clog2(TICK_A_US);
    localparam int TICK_B_BITS = $clog2(TICK_B_US);
    // Capture geometry
    localparam int CAP_W = 8;
    localparam int NUM_CAP = 2;
    localparam int CAP_SEL_W = 3;
    localparam logic [CAP_SEL_W-1:0] PRESCALE_MAX = 3'h4;
    // Port 0 width
    localparam int GPIO_W = 8;
    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_GPIO_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_GPIO_POL = 8'h07;
    localparam logic [ADDR_W-1:0] ADDR_INT_EN = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_TIMER_LO = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_TIMER_HI = 8'h25;
    localparam logic [ADDR_W-1:0] ADDR_CAP_A_RISE = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_CAP_A_FALL = 8'h41;
    localparam logic [ADDR_W-1:0] ADDR_CAP_B_RISE = 8'h42;
    localparam logic [ADDR_W-1:0] ADDR_CAP_B_FALL = 8'h43;
    localparam logic [ADDR_W-1:0] ADDR_CAP_CFG = 8'h44;
    localparam logic [ADDR_W-1:0] ADDR_CAP_STATUS = 8'h45;
    // Request enable bits
    localparam int INT_W = 5;
    localparam int INT_TICK_A = 0;
    localparam int INT_TICK_B = 1;
    localparam int INT_CAP_A = 2;
    localparam int INT_CAP_B = 3;
    localparam int INT_GPIO = 4;
    // Capture status: bit 2*ch is rising, 2*ch+1 is falling
    localparam int STATUS_W = 2 * NUM_CAP;
    // Reset values
    localparam logic [INT_W-1:0] INT_EN_RST = 5'h00;
    localparam logic [CAP_SEL_W-1:0] CAP_CFG_RST = 3'h0;
    localparam logic [GPIO_W-1:0] GPIO_MASK_RST = 8'h00;
    localparam logic [GPIO_W-1:0] GPIO_POL_RST = 8'h00;
endpackage
`default_nettype wire

// ### frt_timer.sv
`timescale 1ns/10ps
`default_nettype none
module frt_timer #(
    parameter int DIV = frt_pkg::DIV_CYCLES,
    parameter int WIDTH = frt_pkg::TIMER_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Timer state and periodic ticks
    output logic [WIDTH-1:0] count_reg,
    output logic tick_a_reg,
    output logic tick_b_reg
);
    import frt_pkg::*;

    localparam int DW = $clog2(DIV);

    logic [DW-1:0] div_reg;
    logic us_en;

    // One pulse per microsecond
    assign us_en = (div_reg == DW'(DIV - 1));

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            div_reg <= '0;
        else if (us_en)
            div_reg <= '0;
        else
            div_reg <= div_reg + 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            count_reg <= '0;
        else if (us_en)
            count_reg <= count_reg + 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_a_reg <= 1'b0;
            tick_b_reg <= 1'b0;
        end
        else
        begin
            tick_a_reg <= us_en && (&count_reg[TICK_A_BITS-1:0]);
            tick_b_reg <= us_en && (&count_reg[TICK_B_BITS-1:0]);
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_count_step: assert property (us_en |=> count_reg == $past(count_reg) + 1'b1)
        else $error("timer did not step");
    a_count_hold: assert property (!us_en |=> $stable(count_reg))
        else $error("timer moved without step");
    a_div_gap: assert property (us_en |=> !us_en [*8])
        else $error("microsecond steps too close");
    a_count_wrap: assert property (us_en && (&count_reg) |=> count_reg == '0)
        else $error("timer did not wrap to zero");
    a_tick_a_align: assert property (tick_a_reg |-> $past(us_en) && count_reg[TICK_A_BITS-1:0] == '0)
        else $error("short tick misaligned");
    a_tick_b_align: assert property (tick_b_reg |-> tick_a_reg && count_reg[TICK_B_BITS-1:0] == '0)
        else $error("long tick misaligned");
    c_long_tick: cover property (tick_b_reg);
endmodule
`default_nettype wire

// ### frt_capture.sv
`timescale 1ns/10ps
`default_nettype none
module frt_capture #(
    parameter int W = frt_pkg::CAP_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pin and timer slice
    input wire logic pin,
    input wire logic [W-1:0] slice,
    // Captured values and events
    output logic [W-1:0] rise_reg,
    output logic [W-1:0] fall_reg,
    output logic rise_evt_reg,
    output logic fall_evt_reg
);
    import frt_pkg::*;

    logic pin_prev_reg;
    logic armed_reg;
    logic rise;
    logic fall;

    // No edge is reported until one sample has been taken after reset
    assign rise = armed_reg && pin && !pin_prev_reg;
    assign fall = armed_reg && !pin && pin_prev_reg;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_prev_reg <= 1'b0;
            armed_reg <= 1'b0;
        end
        else
        begin
            pin_prev_reg <= pin;
            armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rise_reg <= '0;
            fall_reg <= '0;
        end
        else
        begin
            if (rise)
                rise_reg <= slice;
            if (fall)
                fall_reg <= slice;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rise_evt_reg <= 1'b0;
            fall_evt_reg <= 1'b0;
        end
        else
        begin
            rise_evt_reg <= rise;
            fall_evt_reg <= fall;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_rise_load: assert property (rise |=> rise_evt_reg && rise_reg == $past(slice) && $stable(fall_reg))
        else $error("rising capture wrong");
    a_fall_load: assert property (fall |=> fall_evt_reg && fall_reg == $past(slice) && $stable(rise_reg))
        else $error("falling capture wrong");
endmodule
`default_nettype wire

// ### frt_top.sv
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module frt_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [frt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [frt_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [frt_pkg::DATA_W-1:0] reg_rdata_reg,
    // Port 0 pins
    input wire logic [frt_pkg::GPIO_W-1:0] port0_in,
    // Interrupt requests
    output logic tick_a_req_reg,
    output logic tick_b_req_reg,
    output logic cap_a_req_reg,
    output logic cap_b_req_reg,
    output logic gpio_req_reg
);
    import frt_pkg::*;

    logic [TIMER_W-1:0] count;
    logic tick_a;
    logic tick_b;
    logic [CAP_W-1:0] slice;
    logic [CAP_W-1:0] cap_rise [NUM_CAP];
    logic [CAP_W-1:0] cap_fall [NUM_CAP];
    logic [NUM_CAP-1:0] rise_evt;
    logic [NUM_CAP-1:0] fall_evt;
    logic [STATUS_W-1:0] status_set;

    logic [INT_W-1:0] int_en_reg;
    logic [CAP_SEL_W-1:0] cap_cfg_reg;
    logic [STATUS_W-1:0] cap_status_reg;
    logic [GPIO_W-1:0] gpio_mask_reg;
    logic [GPIO_W-1:0] gpio_pol_reg;
    logic [GPIO_W-1:0] gpio_prev_reg;
    logic gpio_armed_reg;
    logic [GPIO_W-1:0] gpio_hit;
    logic [TIMER_W-CAP_W-1:0] msb_hold_reg;
    logic [DATA_W-1:0] rd_next;

    function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
        wr_hit = reg_wr && (reg_addr == a);
    endfunction

    function automatic logic [CAP_W-1:0] slice_of(
        input logic [TIMER_W-1:0] t,
        input logic [CAP_SEL_W-1:0] sel
    );
        logic [CAP_SEL_W-1:0] s;
        s = (sel > PRESCALE_MAX) ? PRESCALE_MAX : sel;
        slice_of = t[s +: CAP_W];
    endfunction

    frt_timer #(
        .DIV(DIV_CYCLES),
        .WIDTH(TIMER_W)
    ) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .count_reg(count),
        .tick_a_reg(tick_a),
        .tick_b_reg(tick_b)
    );

    // Setting n captures timer bits [n+7:n]
    assign slice = slice_of(count, cap_cfg_reg);

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CAP; ch++)
        begin : g_cap
            frt_capture #(
                .W(CAP_W)
            ) u_cap (
                .clock(clock),
                .rst_n(rst_n),
                .pin(port0_in[ch]),
                .slice(slice),
                .rise_reg(cap_rise[ch]),
                .fall_reg(cap_fall[ch]),
                .rise_evt_reg(rise_evt[ch]),
                .fall_evt_reg(fall_evt[ch])
            );
            assign status_set[2*ch] = rise_evt[ch];
            assign status_set[2*ch+1] = fall_evt[ch];
        end
    endgenerate

    // Request enables
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            int_en_reg <= INT_EN_RST;
        else if (wr_hit(ADDR_INT_EN))
            int_en_reg <= reg_wdata[INT_W-1:0];
    end

    // Prescaler select, held to the five legal settings
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cap_cfg_reg <= CAP_CFG_RST;
        else if (wr_hit(ADDR_CAP_CFG))
        begin
            if (reg_wdata[CAP_SEL_W-1:0] > PRESCALE_MAX)
                cap_cfg_reg <= PRESCALE_MAX;
            else
                cap_cfg_reg <= reg_wdata[CAP_SEL_W-1:0];
        end
    end

    // Sticky capture flags, write one to clear, a new capture wins
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cap_status_reg <= '0;
        else if (wr_hit(ADDR_CAP_STATUS))
            cap_status_reg <= (cap_status_reg & ~reg_wdata[STATUS_W-1:0])
                | status_set;
        else
            cap_status_reg <= cap_status_reg | status_set;
    end

    // Port 0 mask and polarity
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gpio_mask_reg <= GPIO_MASK_RST;
            gpio_pol_reg <= GPIO_POL_RST;
        end
        else
        begin
            if (wr_hit(ADDR_GPIO_MASK))
                gpio_mask_reg <= reg_wdata[GPIO_W-1:0];
            if (wr_hit(ADDR_GPIO_POL))
                gpio_pol_reg <= reg_wdata[GPIO_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gpio_prev_reg <= '0;
            gpio_armed_reg <= 1'b0;
        end
        else
        begin
            gpio_prev_reg <= port0_in;
            gpio_armed_reg <= 1'b1;
        end
    end

    // Polarity one selects rising, zero selects falling
    assign gpio_hit = {GPIO_W{gpio_armed_reg}} & gpio_mask_reg
        & ((gpio_pol_reg & port0_in & ~gpio_prev_reg)
        | (~gpio_pol_reg & ~port0_in & gpio_prev_reg));

    // Interrupt requests, one cycle each
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_a_req_reg <= 1'b0;
            tick_b_req_reg <= 1'b0;
            cap_a_req_reg <= 1'b0;
            cap_b_req_reg <= 1'b0;
            gpio_req_reg <= 1'b0;
        end
        else
        begin
            tick_a_req_reg <= tick_a && int_en_reg[INT_TICK_A];
            tick_b_req_reg <= tick_b && int_en_reg[INT_TICK_B];
            cap_a_req_reg <= (rise_evt[0] || fall_evt[0])
                && int_en_reg[INT_CAP_A];
            cap_b_req_reg <= (rise_evt[1] || fall_evt[1])
                && int_en_reg[INT_CAP_B];
            gpio_req_reg <= (|gpio_hit) && int_en_reg[INT_GPIO];
        end
    end

    // Reading the low byte freezes the high nibble for a coherent pair
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            msb_hold_reg <= '0;
        else if (reg_rd && reg_addr == ADDR_TIMER_LO)
            msb_hold_reg <= count[TIMER_W-1:CAP_W];
    end

    always_comb
    begin
        rd_next = '0;
        if (reg_addr == ADDR_TIMER_LO)
            rd_next = count[CAP_W-1:0];
        else if (reg_addr == ADDR_TIMER_HI)
            rd_next = {{(DATA_W-TIMER_W+CAP_W){1'b0}}, msb_hold_reg};
        else if (reg_addr == ADDR_CAP_A_RISE)
            rd_next = cap_rise[0];
        else if (reg_addr == ADDR_CAP_A_FALL)
            rd_next = cap_fall[0];
        else if (reg_addr == ADDR_CAP_B_RISE)
            rd_next = cap_rise[1];
        else if (reg_addr == ADDR_CAP_B_FALL)
            rd_next = cap_fall[1];
        else if (reg_addr == ADDR_CAP_CFG)
            rd_next = {{(DATA_W-CAP_SEL_W){1'b0}}, cap_cfg_reg};
        else if (reg_addr == ADDR_CAP_STATUS)
            rd_next = {{(DATA_W-STATUS_W){1'b0}}, cap_status_reg};
        else if (reg_addr == ADDR_INT_EN)
            rd_next = {{(DATA_W-INT_W){1'b0}}, int_en_reg};
        else if (reg_addr == ADDR_GPIO_MASK)
            rd_next = gpio_mask_reg;
        else if (reg_addr == ADDR_GPIO_POL)
            rd_next = gpio_pol_reg;
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_reg <= '0;
        else if (reg_rd)
            reg_rdata_reg <= rd_next;
        else
            reg_rdata_reg <= '0;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_timer_read: assert property (reg_rd && reg_addr == ADDR_TIMER_LO
        |=> reg_rdata_reg == $past(count[CAP_W-1:0]))
        else $error("timer low byte read wrong");
    a_timer_pair: assert property (reg_rd && reg_addr == ADDR_TIMER_LO
        ##1 reg_rd && reg_addr == ADDR_TIMER_HI
        |=> reg_rdata_reg[TIMER_W-CAP_W-1:0] == $past(count[TIMER_W-1:CAP_W], 2))
        else $error("timer high nibble not coherent");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata_reg == '0)
        else $error("read data outside read cycle");
    a_slice_fine: assert property (rise_evt[0] && $past(cap_cfg_reg) == '0
        |-> cap_rise[0] == $past(count[CAP_W-1:0]))
        else $error("finest slice wrong");
    a_slice_coarse: assert property (fall_evt[1] && $past(cap_cfg_reg) == PRESCALE_MAX
        |-> cap_fall[1] == $past(count[TIMER_W-1:TIMER_W-CAP_W]))
        else $error("coarsest slice wrong");
    a_cfg_legal: assert property (cap_cfg_reg <= PRESCALE_MAX)
        else $error("prescaler outside five settings");
    a_cap_req: assert property ((rise_evt[0] || fall_evt[0]) && int_en_reg[INT_CAP_A]
        |=> cap_a_req_reg)
        else $error("capture A request missing");
    a_cap_req_b: assert property (cap_b_req_reg |-> $past(rise_evt[1] || fall_evt[1]))
        else $error("spurious capture B request");
    a_pin_route: assert property (##2 $rose(port0_in[1]) |=> rise_evt[1])
        else $error("pin B rise not captured");
    a_status_set: assert property (rise_evt[0] |=> cap_status_reg[0])
        else $error("capture flag lost");
    a_tick_req: assert property (tick_a ##1 tick_a_req_reg |-> $past(int_en_reg[INT_TICK_A]))
        else $error("tick request while disabled");
    a_gpio_mask: assert property (gpio_req_reg
        |-> $past(|(gpio_mask_reg & (port0_in ^ gpio_prev_reg))))
        else $error("masked pin raised request");
    a_gpio_pol: assert property (gpio_armed_reg && gpio_mask_reg[0] && !gpio_pol_reg[0]
        && int_en_reg[INT_GPIO] && !port0_in[0] && gpio_prev_reg[0]
        |=> gpio_req_reg)
        else $error("falling edge request missing");

    c_cap_coarse: cover property (rise_evt[0] && cap_cfg_reg == PRESCALE_MAX);
    c_gpio_req: cover property (gpio_req_reg);
    c_tick_b_req: cover property (tick_b_req_reg);
    c_status_clear: cover property (wr_hit(ADDR_CAP_STATUS) && |cap_status_reg);
endmodule
`default_nettype wire

// ### tb_free_run_timer_capture_irq.sv
`timescale 1ns/10ps
`default_nettype none
module tb_free_run_timer_capture_irq;
    import frt_pkg::*;

    logic clock;
    logic rst_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata_reg;
    logic [GPIO_W-1:0] port0_in;
    logic tick_a_req_reg;
    logic tick_b_req_reg;
    logic cap_a_req_reg;
    logic cap_b_req_reg;
    logic gpio_req_reg;
    int n_mismatch = 0;
    int checks = 0;

    frt_top dut_u (
        .clock(clock),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata_reg(reg_rdata_reg),
        .port0_in(port0_in),
        .tick_a_req_reg(tick_a_req_reg),
        .tick_b_req_reg(tick_b_req_reg),
        .cap_a_req_reg(cap_a_req_reg),
        .cap_b_req_reg(cap_b_req_reg),
        .gpio_req_reg(gpio_req_reg)
    );

    always #(CLK_PERIOD_NS / 2) clock = ~clock;

    task automatic give_verdict();
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cmp_val(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic time_out(input string what);
        n_mismatch++;
        $display("[ERR] %s expected event seen none", what);
        give_verdict();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read data is taken in the cycle after the strobe, once it has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_reg;
    endtask

    task automatic rd_timer(output logic [11:0] t);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(ADDR_TIMER_LO, lo);
        rd(ADDR_TIMER_HI, hi);
        t = {hi[3:0], lo};
    endtask

    task automatic check_reset_regs();
        logic [7:0] adr [10] = '{ADDR_INT_EN, ADDR_GPIO_MASK, ADDR_GPIO_POL,
            ADDR_CAP_CFG, ADDR_CAP_STATUS, ADDR_CAP_A_RISE, ADDR_CAP_A_FALL,
            ADDR_CAP_B_RISE, ADDR_CAP_B_FALL, 8'h10};
        logic [7:0] exp [10] = '{8'(INT_EN_RST), GPIO_MASK_RST, GPIO_POL_RST,
            8'(CAP_CFG_RST), 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0] d;
        logic [11:0] t;
        rd_timer(t);
        cmp_val("timer after reset", 16'h0000, 16'(t));
        for (int i = 0; i < 10; i++)
        begin
            rd(adr[i], d);
            cmp_val("reset value", 16'(exp[i]), 16'(d));
        end
    endtask

    task automatic check_reg_access();
        logic [7:0] d;
        wr(ADDR_INT_EN, 8'h1f);
        rd(ADDR_INT_EN, d);
        cmp_val("request enable", 16'h001f, 16'(d));
        wr(ADDR_CAP_CFG, 8'h07);
        rd(ADDR_CAP_CFG, d);
        cmp_val("prescaler clamp", 16'(PRESCALE_MAX), 16'(d));
        wr(8'h10, 8'ha5);
        rd(8'h10, d);
        cmp_val("unmapped read", 16'h0000, 16'(d));
        wr(ADDR_INT_EN, 8'h00);
    endtask

    // Strobes of the two low-byte reads lie exactly ten timer steps apart
    task automatic check_timer_rate();
        logic [11:0] t0;
        logic [11:0] t1;
        logic [11:0] dt;
        rd_timer(t0);
        repeat (10 * DIV_CYCLES - 4) @(posedge clock);
        rd_timer(t1);
        dt = t1 - t0;
        cmp_val("timer advance", 16'h000a, 16'(dt));
    endtask

    task automatic gpio_step(input logic [7:0] pins, input logic exp);
        @(posedge clock);
        port0_in <= pins;
        @(posedge clock);
        #1;
        cmp_val("gpio request", 16'(exp), 16'(gpio_req_reg));
        @(posedge clock);
        #1;
        cmp_val("gpio request end", 16'h0000, 16'(gpio_req_reg));
    endtask

    task automatic check_gpio();
        logic [7:0] d;
        wr(ADDR_GPIO_MASK, 8'h28);
        wr(ADDR_GPIO_POL, 8'h08);
        rd(ADDR_GPIO_POL, d);
        cmp_val("gpio polarity", 16'h0008, 16'(d));
        wr(ADDR_INT_EN, 8'h10);
        gpio_step(8'h08, 1'b1);
        gpio_step(8'h00, 1'b0);
        gpio_step(8'h20, 1'b0);
        gpio_step(8'h00, 1'b1);
        gpio_step(8'h10, 1'b0);
        gpio_step(8'h00, 1'b0);
        gpio_step(8'h20, 1'b0);
        gpio_step(8'h08, 1'b1);
        wr(ADDR_INT_EN, 8'h00);
        gpio_step(8'h20, 1'b0);
        gpio_step(8'h00, 1'b0);
    endtask

    task automatic wait_tick(output int n);
        n = 0;
        while (n < TICK_A_US * DIV_CYCLES + 1000)
        begin
            @(posedge clock);
            #1;
            if (tick_a_req_reg === 1'b1)
            begin
                @(posedge clock);
                #1;
                cmp_val("tick width", 16'h0000, 16'(tick_a_req_reg));
                return;
            end
            n++;
        end
        time_out("tick request");
    endtask

    // Only the long tick is enabled here; the timer is still far below 1024
    task automatic check_ticks();
        int n;
        int nb;
        n = 0;
        nb = 0;
        wr(ADDR_INT_EN, 8'h02);
        repeat (TICK_A_US * DIV_CYCLES + 8)
        begin
            @(posedge clock);
            #1;
            if (tick_a_req_reg !== 1'b0)
                n++;
            if (tick_b_req_reg !== 1'b0)
                nb++;
        end
        cmp_val("masked ticks", 16'h0000, 16'(n));
        cmp_val("early long tick", 16'h0000, 16'(nb));
        wr(ADDR_INT_EN, 8'h03);
        wait_tick(n);
        wait_tick(n);
        cmp_val("tick period", 16'(TICK_A_US * DIV_CYCLES - 2), 16'(n));
        wr(ADDR_INT_EN, 8'h00);
    endtask

    // Retried when the timer stepped between the bracketing reads
    task automatic capture_edge(input int ch, input logic lvl, input int sel,
                                input logic en);
        logic [11:0] t;
        logic [7:0] lo2;
        logic [7:0] d;
        logic [1:0] req_exp;
        int idx;
        idx = 2 * ch + (lvl ? 0 : 1);
        req_exp = en ? 2'(1 << ch) : 2'h0;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clock);
            port0_in[ch] <= ~lvl;
            repeat (4) @(posedge clock);
            wr(ADDR_CAP_STATUS, 8'h0f);
            rd_timer(t);
            @(posedge clock);
            port0_in[ch] <= lvl;
            rd(ADDR_TIMER_LO, lo2);
            cmp_val("capture request", 16'(req_exp),
                    16'({cap_b_req_reg, cap_a_req_reg}));
            @(posedge clock);
            #1;
            cmp_val("capture request end", 16'h0000,
                    16'({cap_b_req_reg, cap_a_req_reg}));
            if (lo2 == t[7:0])
            begin
                rd(ADDR_CAP_A_RISE + 8'(idx), d);
                cmp_val("capture value", 16'((t >> sel) & 12'h0ff), 16'(d));
                rd(ADDR_CAP_STATUS, d);
                cmp_val("capture status", 16'(1 << idx), 16'(d));
                return;
            end
        end
        time_out("capture timing");
    endtask

    task automatic check_captures();
        wr(ADDR_INT_EN, 8'h0c);
        for (int sel = 0; sel <= 4; sel++)
        begin
            wr(ADDR_CAP_CFG, 8'(sel));
            for (int ch = 0; ch < NUM_CAP; ch++)
            begin
                capture_edge(ch, 1'b1, sel, 1'b1);
                capture_edge(ch, 1'b0, sel, 1'b1);
            end
        end
        wr(ADDR_INT_EN, 8'h00);
        capture_edge(1, 1'b1, 4, 1'b0);
    endtask

    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        port0_in = 8'h00;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        check_reset_regs();
        check_reg_access();
        check_timer_rate();
        check_gpio();
        check_ticks();
        check_captures();
        give_verdict();
    end
endmodule
`default_nettype wire
